// file: common/tmr_pkg.sv
// Package: register map, field positions and types of the timer register bank
package tmr_pkg;

  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] OFF_CTL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTL_TWO = 8'h04;
  localparam logic [7:0] OFF_SLAVE = 8'h08;
  localparam logic [7:0] OFF_IRQ_DMA_EN = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_EVT_GEN = 8'h14;
  localparam logic [7:0] OFF_CHMODE_12 = 8'h18;
  localparam logic [7:0] OFF_CHMODE_34 = 8'h1c;
  localparam logic [7:0] OFF_CHAN_EN = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_PRESCALE = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2c;
  localparam logic [7:0] OFF_GAP_A = 8'h30;
  localparam logic [7:0] OFF_CMP_ONE = 8'h34;
  localparam logic [7:0] OFF_CMP_TWO = 8'h38;
  localparam logic [7:0] OFF_CMP_FOUR = 8'h40;
  localparam logic [7:0] OFF_GAP_B = 8'h44;
  localparam logic [7:0] OFF_BURST_CTL = 8'h48;
  localparam logic [7:0] OFF_WINDOW = 8'h4c;
  localparam int NWORDS = 20;

  // ********************
  // Reset values and write masks
  // ********************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] MASK_CTL_ONE = 16'h03ff;
  localparam logic [15:0] MASK_CTL_TWO = 16'h00f8;
  localparam logic [15:0] MASK_SLAVE = 16'hfff7;
  localparam logic [15:0] MASK_IRQ_DMA = 16'h5f5f;
  localparam logic [15:0] MASK_CHAN_EN = 16'h3333;
  localparam logic [15:0] MASK_BURST = 16'h1f1f;
  localparam logic [15:0] MASK_FULL = 16'hffff;

  // ********************
  // Field positions
  // ********************
  localparam int UPD_BIT = 0;
  localparam int CC_LSB = 1;
  localparam int TRG_BIT = 6;
  localparam int UPD_DMA_BIT = 8;
  localparam int CC_DMA_LSB = 9;
  localparam int CC_OVR_LSB = 9;
  localparam int TRG_DMA_BIT = 14;
  localparam int BLEN_LSB = 8;
  localparam int BBASE_LSB = 0;
  localparam int BFIELD_W = 5;

  typedef logic [NWORDS-1:0][15:0] regfile_t;
  typedef enum logic {B_IDLE, B_RUN} burst_st_t;

  // Word index of a byte offset
  function automatic logic [5:0] word_of(input logic [7:0] off);
    word_of = off[7:2];
  endfunction

  // Bits software may store; zero for write-only, window and holes
  function automatic logic [15:0] wmask(input logic [5:0] w);
    case (w)
      word_of(OFF_CTL_ONE): wmask = MASK_CTL_ONE;
      word_of(OFF_CTL_TWO): wmask = MASK_CTL_TWO;
      word_of(OFF_SLAVE): wmask = MASK_SLAVE;
      word_of(OFF_IRQ_DMA_EN): wmask = MASK_IRQ_DMA;
      word_of(OFF_BURST_CTL): wmask = MASK_BURST;
      word_of(OFF_CHAN_EN): wmask = MASK_CHAN_EN;
      word_of(OFF_EVT_GEN), word_of(OFF_WINDOW): wmask = RST_WORD;
      word_of(OFF_GAP_A), word_of(OFF_GAP_B): wmask = RST_WORD;
      default: wmask = (w < 6'(NWORDS)) ? MASK_FULL : RST_WORD;
    endcase
  endfunction

endpackage

// file: common/burst_if.sv
// Interface between the register bank and the burst index sequencer
`timescale 1ns/10ps
`default_nettype none
interface burst_if;
  logic start;
  logic access;
  logic [4:0] base;
  logic [4:0] len;
  logic [4:0] index;
  logic active;
  modport regs (output start, output access, output base, output len, input index, input active);
  modport seq (input start, input access, input base, input len, output index, output active);
endinterface
`default_nettype wire

// file: src/burst_seq.sv
// Burst index sequencer for the window redirection
`timescale 1ns/10ps
`default_nettype none
module burst_seq (
  input wire logic mclk,
  input wire logic rstn,
  burst_if.seq bus
);

  typedef struct packed {
    tmr_pkg::burst_st_t st;
    logic [4:0] idx;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;

  // ********************
  // Next state
  // ********************
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      tmr_pkg::B_IDLE: begin
        if (bus.start) begin
          s_nxt.st = tmr_pkg::B_RUN;
          s_nxt.idx = 5'h00;
        end
      end
      tmr_pkg::B_RUN: begin
        if (bus.access) begin
          if (s_r.idx >= bus.len) begin
            s_nxt.st = tmr_pkg::B_IDLE;
            s_nxt.idx = 5'h00;
          end else begin
            s_nxt.idx = s_r.idx + 5'h01;
          end
        end
      end
      default: begin
        s_nxt.st = tmr_pkg::B_IDLE;
        s_nxt.idx = 5'h00;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.index = s_r.idx;
  assign bus.active = (s_r.st == tmr_pkg::B_RUN);

  // ********************
  // Checks
  // ********************
  chk_index_steps_up: assert property (@(posedge mclk) disable iff (!rstn)
    bus.active && bus.access && s_r.idx < bus.len |=> s_r.idx == $past(s_r.idx) + 5'h01 && bus.active)
    else $error("burst index did not advance");
  chk_index_wraps_zero: assert property (@(posedge mclk) disable iff (!rstn)
    bus.active && bus.access && s_r.idx >= bus.len |=> s_r.idx == 5'h00 && !bus.active)
    else $error("burst index did not return to zero");
  chk_burst_fresh_start: assert property (@(posedge mclk) disable iff (!rstn)
    !bus.active && bus.start |=> bus.active && s_r.idx == 5'h00)
    else $error("burst did not start at base");

endmodule
`default_nettype wire

// file: src/tmr_regbank.sv
// Timer register bank with burst access window for the DMA controller
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Window access goes to control-one plus (base plus index) times four.
// - Index steps by one per window read or write while a burst runs, zero up to burst length.
// - Window is 16-bit read-write at 0x4C, reset 0x0000, all data bits.
// - Each update DMA request moves one whole burst starting at base.
// - Base 0xE targets compare two, then compare three and four.
// - Update DMA requests start only while update DMA enable is set.
// - Registers 0x00 to 0x24 decoded at their offsets, all reset to zero.
// - Enable register: irq enables bits 0-4,6; DMA enables bits 8-12,14.
// - Length field is count minus one; base counts words from control-one.
module tmr_regbank (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic update_evt,
  input wire logic trigger_evt,
  input wire logic [3:0] cc_evt,
  output logic update_dma_req,
  output logic [3:0] cc_dma_req,
  output logic trigger_dma_req,
  output logic irq,
  output logic soft_update,
  output logic [15:0] control_one_q,
  output logic [15:0] count_value_q,
  output logic [15:0] compare_two_q
);

  // ********************
  // Word indices
  // ********************
  localparam logic [5:0] W_CTL_ONE = tmr_pkg::word_of(tmr_pkg::OFF_CTL_ONE);
  localparam logic [5:0] W_IRQ_DMA = tmr_pkg::word_of(tmr_pkg::OFF_IRQ_DMA_EN);
  localparam logic [5:0] W_FLAGS = tmr_pkg::word_of(tmr_pkg::OFF_FLAGS);
  localparam logic [5:0] W_EVT_GEN = tmr_pkg::word_of(tmr_pkg::OFF_EVT_GEN);
  localparam logic [5:0] W_COUNT = tmr_pkg::word_of(tmr_pkg::OFF_COUNT);
  localparam logic [5:0] W_CMP_TWO = tmr_pkg::word_of(tmr_pkg::OFF_CMP_TWO);
  localparam logic [5:0] W_BURST = tmr_pkg::word_of(tmr_pkg::OFF_BURST_CTL);

  typedef struct packed {
    tmr_pkg::regfile_t regs;
    logic [15:0] rdata;
    logic soft_upd;
  } bank_t;

  bank_t s_r;
  bank_t s_nxt;

  burst_if bif ();

  // Word targeted through the window
  function automatic logic [5:0] win_target(input logic [4:0] base, input logic [4:0] idx);
    win_target = {1'b0, base} + {1'b0, idx};
  endfunction

  // Readable contents of one word, zero for holes and write-only words
  function automatic logic [15:0] read_word(input tmr_pkg::regfile_t regs, input logic [5:0] w);
    logic [15:0] v;
    v = tmr_pkg::RST_WORD;
    if (w == W_FLAGS) begin
      v = regs[W_FLAGS];
    end else if (w < 6'(tmr_pkg::NWORDS)) begin
      v = regs[w[4:0]] & tmr_pkg::wmask(w);
    end
    read_word = v;
  endfunction

  logic win_hit;
  logic [5:0] eff_word;
  logic [4:0] b_base;
  logic [4:0] b_len;
  logic gen_upd;
  logic upd_now;
  logic [15:0] gen_bits;
  logic [15:0] flag_word;
  logic [15:0] en_word;

  // ********************
  // Address resolution
  // ********************
  always_comb begin
    b_base = s_r.regs[W_BURST][tmr_pkg::BBASE_LSB +: tmr_pkg::BFIELD_W];
    b_len = s_r.regs[W_BURST][tmr_pkg::BLEN_LSB +: tmr_pkg::BFIELD_W];
    win_hit = (addr == tmr_pkg::OFF_WINDOW);
    eff_word = win_hit ? win_target(b_base, bif.index) : addr[7:2];
    gen_bits = (wr_stb && eff_word == W_EVT_GEN) ? wdata : tmr_pkg::RST_WORD;
    gen_upd = gen_bits[tmr_pkg::UPD_BIT];
    upd_now = update_evt | gen_upd;
    flag_word = s_r.regs[W_FLAGS];
    en_word = s_r.regs[W_IRQ_DMA];
  end

  // ********************
  // Register next state
  // ********************
  always_comb begin
    s_nxt = s_r;
    s_nxt.soft_upd = gen_upd;
    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = rd_stb ? read_word(s_r.regs, eff_word) : tmr_pkg::RST_WORD;
    // Stores; flags clear by writing one
    if (wr_stb && eff_word < 6'(tmr_pkg::NWORDS)) begin
      if (eff_word == W_FLAGS) begin
        s_nxt.regs[W_FLAGS] = s_r.regs[W_FLAGS] & ~wdata;
      end else begin
        s_nxt.regs[eff_word[4:0]] = (s_r.regs[eff_word[4:0]] & ~tmr_pkg::wmask(eff_word))
          | (wdata & tmr_pkg::wmask(eff_word));
      end
    end
    // Events set flags after the clear so a same-cycle event wins
    if (upd_now) begin
      s_nxt.regs[W_FLAGS][tmr_pkg::UPD_BIT] = 1'b1;
    end
    if (trigger_evt || gen_bits[tmr_pkg::TRG_BIT]) begin
      s_nxt.regs[W_FLAGS][tmr_pkg::TRG_BIT] = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      if (cc_evt[i] || gen_bits[tmr_pkg::CC_LSB + i]) begin
        s_nxt.regs[W_FLAGS][tmr_pkg::CC_LSB + i] = 1'b1;
      end
      // Capture on an already pending flag marks an overcapture
      if (cc_evt[i] && flag_word[tmr_pkg::CC_LSB + i]) begin
        s_nxt.regs[W_FLAGS][tmr_pkg::CC_OVR_LSB + i] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************
  // Burst sequencer hookup
  // ********************
  assign bif.start = upd_now & en_word[tmr_pkg::UPD_DMA_BIT];
  assign bif.access = win_hit & (rd_stb | wr_stb);
  assign bif.base = b_base;
  assign bif.len = b_len;

  burst_seq u_seq (
    .mclk(mclk),
    .rstn(rstn),
    .bus(bif)
  );

  // ********************
  // Outputs
  // ********************
  assign rdata = s_r.rdata;
  assign update_dma_req = bif.active;
  assign cc_dma_req = flag_word[tmr_pkg::CC_LSB +: 4] & en_word[tmr_pkg::CC_DMA_LSB +: 4];
  assign trigger_dma_req = flag_word[tmr_pkg::TRG_BIT] & en_word[tmr_pkg::TRG_DMA_BIT];
  // Level interrupt while an enabled flag is pending
  assign irq = |(flag_word[6:0] & en_word[6:0]);
  assign soft_update = s_r.soft_upd;
  assign control_one_q = s_r.regs[W_CTL_ONE];
  assign count_value_q = s_r.regs[W_COUNT];
  assign compare_two_q = s_r.regs[W_CMP_TWO];

  // ********************
  // Checks
  // ********************
  chk_window_write_target: assert property (@(posedge mclk) disable iff (!rstn)
    wr_stb && win_hit && b_base == 5'h0e && bif.index == 5'h01
    |=> s_r.regs[15] == $past(wdata))
    else $error("window write missed compare three");
  chk_base_hits_cmp2: assert property (@(posedge mclk) disable iff (!rstn)
    wr_stb && win_hit && b_base == 5'h0e && bif.index == 5'h00
    |=> compare_two_q == $past(wdata))
    else $error("base 0xE did not reach compare two");
  chk_window_read_direct: assert property (@(posedge mclk) disable iff (!rstn)
    rd_stb && win_hit && b_base == 5'h09 && bif.index == 5'h00
    |=> rdata == $past(count_value_q))
    else $error("window read did not return target");
  chk_dma_gated_off: assert property (@(posedge mclk) disable iff (!rstn)
    !update_dma_req && upd_now && !en_word[tmr_pkg::UPD_DMA_BIT] |=> !update_dma_req)
    else $error("update DMA request while disabled");
  chk_dma_gated_on: assert property (@(posedge mclk) disable iff (!rstn)
    !update_dma_req && update_evt && en_word[tmr_pkg::UPD_DMA_BIT] |=> update_dma_req)
    else $error("update DMA request missing");
  chk_burst_len_field: assert property (@(posedge mclk) disable iff (!rstn)
    wr_stb && addr == tmr_pkg::OFF_BURST_CTL |=> b_len == $past(wdata[12:8]))
    else $error("burst length field misplaced");
  chk_update_irq: assert property (@(posedge mclk) disable iff (!rstn)
    update_evt && en_word[tmr_pkg::UPD_BIT] && !(wr_stb && eff_word == W_IRQ_DMA) |=> irq)
    else $error("update interrupt not raised");
  chk_whole_burst_len: assert property (@(posedge mclk) disable iff (!rstn)
    update_dma_req && b_len == 5'h02 && bif.index == 5'h00 && bif.access
    ##2 bif.access ##2 bif.access |=> !update_dma_req)
    else $error("burst of three did not end");
  chk_flag_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
    update_evt && wr_stb && addr == tmr_pkg::OFF_FLAGS |=> flag_word[tmr_pkg::UPD_BIT])
    else $error("update flag lost on clear");
  chk_trigger_dma_path: assert property (@(posedge mclk) disable iff (!rstn)
    trigger_evt && en_word[tmr_pkg::TRG_DMA_BIT] && !(wr_stb && eff_word == W_IRQ_DMA) |=> trigger_dma_req)
    else $error("trigger DMA request missing");
  chk_cc1_dma_path: assert property (@(posedge mclk) disable iff (!rstn)
    cc_evt[0] && en_word[tmr_pkg::CC_DMA_LSB] && !(wr_stb && eff_word == W_IRQ_DMA) |=> cc_dma_req[0])
    else $error("channel one DMA request missing");
  chk_enable_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
    rd_stb && addr == tmr_pkg::OFF_IRQ_DMA_EN |=> (rdata & ~tmr_pkg::MASK_IRQ_DMA) == tmr_pkg::RST_WORD)
    else $error("reserved enable bits read back");

endmodule
`default_nettype wire

// file: tb/dma_model.sv
// Behavioural DMA controller that answers update requests with window writes
`timescale 1ns/10ps
`default_nettype none
module dma_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req,
  input wire logic slow,
  output logic [7:0] m_addr,
  output logic [15:0] m_wdata,
  output logic m_wr
);
  logic [15:0] n_r;
  logic [1:0] gap_r;
  // One window write per transfer, then at least one idle cycle before the request is looked at again
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      m_wr <= 1'b0;
      m_addr <= 8'hff;
      m_wdata <= 16'h0000;
      n_r <= 16'h0000;
      gap_r <= 2'h0;
    end else if (m_wr) begin
      m_wr <= 1'b0;
      m_addr <= ~m_addr; // Released lines do not keep the last value
      m_wdata <= ~m_wdata;
      gap_r <= slow ? 2'h3 : 2'h0;
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end else if (req) begin
      m_wr <= 1'b1;
      m_addr <= 8'h4c;
      m_wdata <= 16'h5a00 + n_r;
      n_r <= n_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_tmr_regbank.sv
// Testbench of the timer register bank with burst window
`timescale 1ns/10ps
`default_nettype none
module tb_tmr_regbank;
  logic mclk, rstn, t_wr, rd_stb, update_evt, trigger_evt, slow, m_wr;
  logic update_dma_req, trigger_dma_req, irq, soft_update;
  logic [7:0] t_addr, m_addr;
  logic [15:0] t_wdata, m_wdata, rdata, c2q, d, c1q, cntq;
  logic [3:0] cc_evt, cc_dma_req;
  int num_errors, compares;

  // ********************
  // Design and DMA partner sharing the register port
  // ********************
  tmr_regbank uut (.mclk(mclk), .rstn(rstn), .addr(m_wr ? m_addr : t_addr), .wdata(m_wr ? m_wdata : t_wdata),
    .wr_stb(t_wr | m_wr), .rd_stb(rd_stb), .rdata(rdata), .update_evt(update_evt), .trigger_evt(trigger_evt),
    .cc_evt(cc_evt), .update_dma_req(update_dma_req), .cc_dma_req(cc_dma_req), .trigger_dma_req(trigger_dma_req),
    .irq(irq), .soft_update(soft_update), .control_one_q(c1q), .count_value_q(cntq), .compare_two_q(c2q));
  dma_model dma (.mclk(mclk), .rstn(rstn), .req(update_dma_req), .slow(slow), .m_addr(m_addr),
    .m_wdata(m_wdata), .m_wr(m_wr));

  // ********************
  // Bus tasks and comparisons
  // ********************
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    t_addr <= a;
    t_wdata <= v;
    t_wr <= 1'b1;
    @(posedge mclk);
    t_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    t_addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk_word(v, exp);
  endtask
  task automatic upd();
    @(posedge mclk);
    update_evt <= 1'b1;
    @(posedge mclk);
    update_evt <= 1'b0;
    #1;
  endtask
  task automatic evt(input logic [3:0] c, input logic t);
    @(posedge mclk);
    cc_evt <= c;
    trigger_evt <= t;
    @(posedge mclk);
    cc_evt <= 4'h0;
    trigger_evt <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && (update_dma_req !== 1'b0 || m_wr !== 1'b0); i++) begin
      @(posedge mclk);
      #1;
    end
    chk_bit(update_dma_req, 1'b0);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********************
  // Test sequence
  // ********************
  initial begin
    {rstn, t_wr, rd_stb, update_evt, trigger_evt, slow} = 6'h00;
    t_addr = 8'h00;
    t_wdata = 16'h0000;
    cc_evt = 4'h0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rchk(8'(a), 16'h0000);
    rchk(8'h4c, 16'h0000);
    wr(8'h0c, 16'hffff);
    rchk(8'h0c, 16'h5f5f);
    wr(8'h30, 16'hffff);
    rchk(8'h30, 16'h0000);
    wr(8'h00, 16'hffff);
    #1 chk_word(c1q, 16'h03ff);
    rchk(8'h00, 16'h03ff);
    $display("test reset and masks done");
    wr(8'h0c, 16'h0000);
    wr(8'h48, 16'h020e);
    upd();
    chk_bit(update_dma_req, 1'b0);
    repeat (4) @(posedge mclk);
    rchk(8'h38, 16'h0000);
    $display("test gated request done");
    wr(8'h0c, 16'h0100);
    upd();
    chk_bit(update_dma_req, 1'b1);
    wait_idle();
    rchk(8'h38, 16'h5a00);
    rchk(8'h3c, 16'h5a01);
    rchk(8'h40, 16'h5a02);
    slow = 1'b1;
    upd();
    wait_idle();
    rchk(8'h38, 16'h5a03);
    rchk(8'h3c, 16'h5a04);
    rchk(8'h40, 16'h5a05);
    chk_word(c2q, 16'h5a03);
    rchk(8'h4c, 16'h5a03);
    $display("test bursts done");
    wr(8'h48, 16'h000d);
    wr(8'h14, 16'h0001);
    #1 chk_bit(soft_update, 1'b1);
    wait_idle();
    rchk(8'h34, 16'h5a06);
    rchk(8'h38, 16'h5a03);
    $display("test single transfer done");
    wr(8'h48, 16'h0009);
    wr(8'h24, 16'h1234);
    #1 chk_word(cntq, 16'h1234);
    rchk(8'h4c, 16'h1234);
    wr(8'h4c, 16'h4321);
    rchk(8'h24, 16'h4321);
    $display("test idle window done");
    wr(8'h0c, 16'h0002);
    evt(4'h1, 1'b0);
    chk_bit(irq, 1'b1);
    rd(8'h10, d);
    chk_bit(d[1], 1'b1);
    wr(8'h10, 16'h0002);
    #1 chk_bit(irq, 1'b0);
    wr(8'h0c, 16'h0000);
    evt(4'h1, 1'b0);
    chk_bit(irq, 1'b0);
    wr(8'h0c, 16'h0002);
    #1 chk_bit(irq, 1'b1);
    $display("test interrupt done");
    // Trigger and channel DMA requests, overcapture on a pending flag
    wr(8'h0c, 16'h4200);
    evt(4'h1, 1'b1);
    chk_bit(trigger_dma_req, 1'b1);
    chk_word({12'h000, cc_dma_req}, 16'h0001);
    chk_bit(irq, 1'b0);
    // Update event and flag clear in one cycle: the event wins
    wr(8'h0c, 16'h0001);
    wr(8'h10, 16'h0001);
    #1 chk_bit(irq, 1'b0);
    fork
      upd();
      wr(8'h10, 16'h0001);
    join
    chk_bit(irq, 1'b1);
    rchk(8'h10, 16'h0243);
    $display("test flags and requests done");
    print_verdict();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
